// ---- hdl/frh_call_filter.sv ----
`timescale 1ns/100ps
module frh_call_filter
	import frh_pkg::*;
(
	input  wire logic          cc_check_i,
	input  wire logic          addr_check_i,
	input  wire logic          beacon_i,
	input  wire logic [3:0]    cc_index_i,
	input  wire logic [23:0]   own_id_i,
	input  frh_block_type      blk_i,
	output wire logic          cc_ok_o,
	output wire logic          accept_o
);
	wire id_ok;

	assign cc_ok_o = (blk_i.colour == cc_index_i);
	// Broadcast, all-call and beacon traffic bypass the identity compare
	assign id_ok = (blk_i.kind == BT_BROADCAST) | blk_i.all_call | beacon_i
		| (blk_i.target == own_id_i);
	// Colour and address checks are ANDed; with cc_check_i set a colour mismatch rejects whatever the address says
	assign accept_o = (~cc_check_i | cc_ok_o) & (~addr_check_i | id_ok);
endmodule

// ---- hdl/frh_frame_handler.sv ----
// Local design decision: register access over APB.
`timescale 1ns/100ps
module frh_frame_handler
	import frh_pkg::*;
(
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          psel_i,
	input  wire logic          penable_i,
	input  wire logic          pwrite_i,
	input  wire logic [11:0]   paddr_i,
	input  wire logic [31:0]   pwdata_i,
	output logic      [31:0]   prdata_o,
	output logic               pready_o,
	output logic               pslverr_o,
	input  wire logic          frame_tick_i,
	input  wire logic          frame_sync_ok_i,
	input  wire logic          burst_start_sync_i,
	input  wire logic          mid_call_sync_i,
	input  wire logic          blk_valid_i,
	input  frh_block_type      blk_i,
	output logic               demod_en_o,
	output logic               sync_found_irq_o,
	output logic               call_accepted_irq_o,
	output logic               event_irq_o,
	output logic               block_ready_irq_o,
	output logic               voc_en_o,
	output logic               voc_llr_valid_o,
	output logic      [3:0]    voc_llr_o
);
	function automatic logic [11:0] hard_pack(input logic [47:0] d);
		logic [11:0] h;
		h = 12'h000;
		for (int i = 0; i < 12; i++) begin
			h[i] = d[4 * i + 3];
		end
		return h;
	endfunction

	logic [15:0]        cfg_q;
	logic [15:0]        mode_q;
	logic [15:0]        aux_q;
	logic [15:0]        own_lo_q;
	logic [15:0]        own_hi_q;
	logic [15:0]        thr_q;
	logic [3:0][15:0]   rxw_q;
	logic               unread_q;
	logic               overrun_q;
	frh_state_type      state_q;
	frh_state_type      state_d;
	logic [1:0]         cch_idx_q;
	logic [35:0]        collect_q;
	logic [1:0]         sf_cnt_q;
	logic               sf_ok_q;
	logic [15:0]        corrupt_q;
	logic               voc_active_q;
	logic [47:0]        voc_sh_q;
	logic [3:0]         voc_cnt_q;
	logic [15:0]        rd_data;
	logic               rd_hit;
	logic               fwd;
	logic               fwd_rep;
	logic               acc_ev;
	logic               sync_ev;
	logic               collect_en;
	logic               voc_load;
	frh_block_type      rep_blk;
	frh_block_type      filt_blk;
	frh_block_type      fwd_blk;
	logic [3:0][15:0]   fwd_words;

	// APB decode
	wire       setup   = psel_i & ~penable_i;
	wire       access  = psel_i & penable_i & pready_o;
	wire [9:0] idx     = paddr_i[11:2];
	wire       aligned = (paddr_i[1:0] == 2'h0);
	wire       wr_en   = access & pwrite_i & aligned;
	wire       rd_w0   = access & ~pwrite_i & aligned & (idx == IDX_RX_WORD0);
	wire       wr_stat = wr_en & (idx == IDX_STATUS);

	always_comb begin
		rd_hit  = 1'b1;
		rd_data = 16'h0000;
		if (!aligned) begin
			rd_hit = 1'b0;
		end else if (idx == IDX_MODEM_CFG) begin
			rd_data = cfg_q;
		end else if (idx == IDX_RX_WORD0) begin
			rd_data = rxw_q[0];
		end else if (idx == IDX_RX_WORD1) begin
			rd_data = rxw_q[1];
		end else if (idx == IDX_RX_WORD2) begin
			rd_data = rxw_q[2];
		end else if (idx == IDX_RX_WORD3) begin
			rd_data = rxw_q[3];
		end else if (idx == IDX_MODE_CTRL) begin
			rd_data = mode_q;
		end else if (idx == IDX_AUX) begin
			rd_data = aux_q;
		end else if (idx == IDX_OWN_ID_LO) begin
			rd_data = own_lo_q;
		end else if (idx == IDX_OWN_ID_HI) begin
			rd_data = own_hi_q;
		end else if (idx == IDX_CORRUPT_THR) begin
			rd_data = thr_q;
		end else if (idx == IDX_STATUS) begin
			rd_data = {9'h000, 3'(state_q), voc_active_q, (state_q == S_CALL), unread_q,
				overrun_q};
		end else begin
			rd_hit = 1'b0;
		end
	end

	// No wait state: data is sampled in setup and presented with pready
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h00000000;
		end else begin
			pready_o  <= setup;
			pslverr_o <= setup & ~rd_hit;
			if (setup) begin
				prdata_o <= {16'h0000, rd_data};
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_q    <= CFG_RESET;
			mode_q   <= MODE_RESET;
			aux_q    <= AUX_RESET;
			own_lo_q <= OWN_ID_RESET;
			own_hi_q <= OWN_ID_RESET;
			thr_q    <= THR_RESET;
		end else if (wr_en) begin
			if (idx == IDX_MODEM_CFG) begin
				cfg_q <= pwdata_i[15:0];
			end else if (idx == IDX_MODE_CTRL) begin
				mode_q <= pwdata_i[15:0];
			end else if (idx == IDX_AUX) begin
				aux_q <= pwdata_i[15:0];
			end else if (idx == IDX_OWN_ID_LO) begin
				own_lo_q <= pwdata_i[15:0];
			end else if (idx == IDX_OWN_ID_HI) begin
				own_hi_q <= pwdata_i[15:0];
			end else if (idx == IDX_CORRUPT_THR) begin
				thr_q <= pwdata_i[15:0];
			end
		end
	end

	// Control
	wire rx_mode      = (mode_q == MODE_RX);
	wire beacon       = cfg_q[CFG_BEACON_BIT];
	wire addr_chk     = cfg_q[CFG_ADDR_BIT];
	wire cc_chk       = cfg_q[CFG_CC_BIT];
	wire addr_collect = addr_chk & ~beacon;
	wire blk_go       = blk_valid_i & rx_mode;
	wire is_msg       = (blk_i.kind == BT_MESSAGE) | (blk_i.kind == BT_BROADCAST);
	wire is_cch       = (blk_i.kind == BT_CCH);
	wire is_payload   = (blk_i.kind == BT_PAYLOAD);
	wire is_end       = (blk_i.kind == BT_END);
	wire in_call      = (state_q == S_CALL);
	wire burst_found;
	wire mid_found;
	wire cc_ok;
	wire accept;

	frh_sync_hunter u_hunter (
		.clk_i              (clk_i),
		.rst_i              (rst_i),
		.hunt_i             (state_q == S_HUNT),
		.frame_tick_i       (frame_tick_i),
		.burst_start_sync_i (burst_start_sync_i),
		.mid_call_sync_i    (mid_call_sync_i),
		.burst_found_o      (burst_found),
		.mid_found_o        (mid_found)
	);

	// Four control blocks give 12 bits each, rebuilt as a message block
	wire [47:0] rep_data = {collect_q, blk_i.data[11:0]};
	always_comb begin
		rep_blk          = blk_i;
		rep_blk.kind     = BT_MESSAGE;
		rep_blk.data     = rep_data;
		rep_blk.target   = rep_data[47:24];
		rep_blk.all_call = &rep_data[47:24];
		rep_blk.voice    = rep_data[23];
	end
	assign filt_blk = fwd_rep ? rep_blk : blk_i;
	assign fwd_blk  = fwd_rep ? rep_blk : blk_i;

	frh_call_filter u_filter (
		.cc_check_i   (cc_chk),
		.addr_check_i (addr_chk),
		.beacon_i     (beacon),
		.cc_index_i   (aux_q[3:0]),
		.own_id_i     ({own_hi_q[7:0], own_lo_q}),
		.blk_i        (filt_blk),
		.cc_ok_o      (cc_ok),
		.accept_o     (accept)
	);

	// Supervision of an established payload call
	wire blk_chk  = blk_go & in_call & (is_cch | is_payload);
	wire blk_bad  = ~blk_i.crc_ok | (cc_chk & ~cc_ok);
	wire sync_bad = in_call & frame_tick_i & ~frame_sync_ok_i;
	wire evt_err  = (blk_chk & blk_bad) | sync_bad;
	wire sf_ok    = sf_ok_q | (frame_tick_i & frame_sync_ok_i) | (blk_chk & ~blk_bad);
	wire sf_end   = in_call & frame_tick_i & (sf_cnt_q == SF_LAST_FRAME);
	wire [16:0] corrupt_inc = {1'b0, corrupt_q} + 17'h00001;
	wire corrupt_drop = sf_end & ~sf_ok & (corrupt_inc >= {1'b0, thr_q});

	always_comb begin
		state_d    = state_q;
		fwd        = 1'b0;
		fwd_rep    = 1'b0;
		acc_ev     = 1'b0;
		sync_ev    = 1'b0;
		collect_en = 1'b0;
		voc_load   = 1'b0;
		case (state_q)
			S_IDLE: begin
				if (rx_mode) begin
					state_d = S_HUNT;
				end
			end
			S_HUNT: begin
				if (burst_found) begin
					state_d = S_MSG;
					sync_ev = 1'b1;
				end else if (mid_found) begin
					state_d = S_CCH;
					sync_ev = 1'b1;
				end
			end
			S_MSG: begin
				if (blk_go && is_msg) begin
					if (blk_i.crc_ok) begin
						// First valid copy decides; a message twin then arrives in call and is dropped, a broadcast twin is forwarded
						if (accept) begin
							fwd     = 1'b1;
							acc_ev  = 1'b1;
							state_d = S_CALL;
						end else begin
							state_d = S_HUNT;
						end
					end else if (blk_i.copy) begin
						state_d = S_HUNT;
					end
				end
			end
			S_CCH: begin
				if (blk_go && is_cch) begin
					if (!blk_i.crc_ok) begin
						state_d = S_HUNT;
					end else if (addr_collect) begin
						collect_en = 1'b1;
						if (cch_idx_q == CCH_LAST) begin
							fwd_rep = 1'b1;
							if (accept) begin
								fwd     = 1'b1;
								acc_ev  = 1'b1;
								state_d = S_CALL;
							end else begin
								state_d = S_HUNT;
							end
						end
					end else if (accept) begin
						fwd     = 1'b1;
						acc_ev  = 1'b1;
						state_d = S_CALL;
					end else begin
						state_d = S_HUNT;
					end
				end
			end
			S_CALL: begin
				if (corrupt_drop) begin
					state_d = S_HUNT;
				end else if (blk_go) begin
					if (is_end) begin
						fwd     = 1'b1;
						state_d = S_HUNT;
					end else if (is_payload && voc_active_q) begin
						voc_load = 1'b1;
					end else if (blk_i.kind != BT_MESSAGE) begin
						fwd = 1'b1;
					end
				end
			end
			default: begin
				state_d = S_IDLE;
			end
		endcase
		if (!rx_mode) begin
			state_d = S_IDLE;
		end
	end

	// Host words; payload may be reduced to sign bits
	wire hard_pl = (fwd_blk.kind == BT_PAYLOAD) & cfg_q[CFG_HARD_BIT];
	assign fwd_words[0] = {fwd_blk.data[47:40], 1'b0, fwd_blk.kind, WORD_COUNT};
	assign fwd_words[1] = hard_pl ? {4'h0, hard_pack(fwd_blk.data)} : fwd_blk.data[39:24];
	assign fwd_words[2] = hard_pl ? 16'h0000 : fwd_blk.data[23:8];
	assign fwd_words[3] = hard_pl ? 16'h0000 : {fwd_blk.data[7:0], 8'h00};

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rxw_q     <= '0;
			unread_q  <= 1'b0;
			overrun_q <= 1'b0;
		end else begin
			if (fwd) begin
				rxw_q <= fwd_words;
			end
			// New block wins over a read or clear in the same cycle
			unread_q  <= fwd | (unread_q & ~rd_w0);
			overrun_q <= (fwd & unread_q) | (overrun_q & ~(wr_stat & pwdata_i[STAT_OVERRUN]));
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q   <= S_IDLE;
			cch_idx_q <= 2'h0;
			collect_q <= 36'h000000000;
			sf_cnt_q  <= 2'h0;
			sf_ok_q   <= 1'b0;
			corrupt_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			if (state_q != S_CCH) begin
				cch_idx_q <= 2'h0;
			end else if (collect_en) begin
				cch_idx_q <= cch_idx_q + 2'h1;
				collect_q <= {collect_q[23:0], blk_i.data[11:0]};
			end
			if (!in_call) begin
				sf_cnt_q  <= 2'h0;
				sf_ok_q   <= 1'b0;
				corrupt_q <= 16'h0000;
			end else if (sf_end) begin
				sf_cnt_q  <= 2'h0;
				sf_ok_q   <= 1'b0;
				corrupt_q <= sf_ok ? 16'h0000 : corrupt_inc[15:0];
			end else begin
				sf_cnt_q <= sf_cnt_q + {1'b0, frame_tick_i};
				sf_ok_q  <= sf_ok;
			end
		end
	end

	// Event outputs and vocoder feed
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			demod_en_o          <= 1'b0;
			sync_found_irq_o    <= 1'b0;
			call_accepted_irq_o <= 1'b0;
			event_irq_o         <= 1'b0;
			block_ready_irq_o   <= 1'b0;
			voc_active_q        <= 1'b0;
			voc_en_o            <= 1'b0;
			voc_sh_q            <= 48'h000000000000;
			voc_cnt_q           <= 4'h0;
			voc_llr_valid_o     <= 1'b0;
			voc_llr_o           <= 4'h0;
		end else begin
			demod_en_o          <= (state_d == S_MSG) | (state_d == S_CCH)
				| (state_d == S_CALL);
			sync_found_irq_o    <= sync_ev;
			call_accepted_irq_o <= acc_ev;
			event_irq_o         <= evt_err | corrupt_drop;
			block_ready_irq_o   <= fwd;
			if (state_d != S_CALL) begin
				voc_active_q <= 1'b0;
			end else if (acc_ev) begin
				voc_active_q <= cfg_q[CFG_VOC_EN_BIT] & filt_blk.voice;
			end
			voc_en_o <= (state_d == S_CALL) & (voc_active_q
				| (acc_ev & cfg_q[CFG_VOC_EN_BIT] & filt_blk.voice));
			// Leaving the call cuts the feed; a new payload block restarts it
			if (state_d != S_CALL) begin
				voc_cnt_q <= 4'h0;
			end else if (voc_load) begin
				voc_sh_q  <= blk_i.data;
				voc_cnt_q <= LLR_PER_BLOCK;
			end else if (voc_cnt_q != 4'h0) begin
				voc_sh_q  <= {voc_sh_q[43:0], 4'h0};
				voc_cnt_q <= voc_cnt_q - 4'h1;
			end
			voc_llr_valid_o <= ~voc_load & (voc_cnt_q != 4'h0) & (state_d == S_CALL);
			voc_llr_o       <= voc_sh_q[47:44];
		end
	end
endmodule

// ---- hdl/frh_sync_hunter.sv ----
`timescale 1ns/100ps
module frh_sync_hunter
	import frh_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic hunt_i,
	input  wire logic frame_tick_i,
	input  wire logic burst_start_sync_i,
	input  wire logic mid_call_sync_i,
	output wire logic burst_found_o,
	output wire logic mid_found_o
);
	logic       armed_q;
	logic [1:0] gap_q;

	assign burst_found_o = hunt_i & burst_start_sync_i;
	// Second mid-call copy must land exactly two frame ticks after the first
	assign mid_found_o = hunt_i & mid_call_sync_i & ~burst_start_sync_i & armed_q
		& (gap_q == LATE_ENTRY_FRAMES);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			armed_q <= 1'b0;
			gap_q   <= 2'h0;
		end else if (!hunt_i) begin
			armed_q <= 1'b0;
		end else if (mid_call_sync_i) begin
			armed_q <= 1'b1;
			gap_q   <= 2'h0;
		end else if (frame_tick_i && armed_q) begin
			if (gap_q == LATE_ENTRY_FRAMES) begin
				armed_q <= 1'b0;
			end else begin
				gap_q <= gap_q + 2'h1;
			end
		end
	end
endmodule

// ---- inc/frh_pkg.sv ----
package frh_pkg;
	// Register indices; byte address is four times the index
	localparam logic [9:0]  IDX_MODEM_CFG   = 10'h0A1;
	localparam logic [9:0]  IDX_RX_WORD0    = 10'h0B8;
	localparam logic [9:0]  IDX_RX_WORD1    = 10'h0B9;
	localparam logic [9:0]  IDX_RX_WORD2    = 10'h0BA;
	localparam logic [9:0]  IDX_RX_WORD3    = 10'h0BB;
	localparam logic [9:0]  IDX_MODE_CTRL   = 10'h0C1;
	localparam logic [9:0]  IDX_AUX         = 10'h0C2;
	localparam logic [9:0]  IDX_OWN_ID_LO   = 10'h0D0;
	localparam logic [9:0]  IDX_OWN_ID_HI   = 10'h0D1;
	localparam logic [9:0]  IDX_CORRUPT_THR = 10'h0D2;
	localparam logic [9:0]  IDX_STATUS      = 10'h0D3;

	localparam logic [15:0] MODE_RX         = 16'h0011;
	localparam logic [15:0] MODE_RESET      = 16'h0000;
	localparam logic [15:0] CFG_RESET       = 16'h0000;
	localparam logic [15:0] AUX_RESET       = 16'h0000;
	localparam logic [15:0] OWN_ID_RESET    = 16'h0000;
	localparam logic [15:0] THR_RESET       = 16'h0003;

	localparam int unsigned CFG_VOC_EN_BIT  = 0;
	localparam int unsigned CFG_HARD_BIT    = 1;
	localparam int unsigned CFG_ADDR_BIT    = 9;
	localparam int unsigned CFG_CC_BIT      = 10;
	localparam int unsigned CFG_BEACON_BIT  = 12;
	localparam int unsigned STAT_OVERRUN    = 0;
	localparam int unsigned STAT_UNREAD     = 1;
	localparam int unsigned STAT_CALL       = 2;
	localparam int unsigned STAT_VOC        = 3;

	localparam logic [2:0]  BT_MESSAGE      = 3'h0;
	localparam logic [2:0]  BT_BROADCAST    = 3'h1;
	localparam logic [2:0]  BT_APPENDED     = 3'h2;
	localparam logic [2:0]  BT_CCH          = 3'h3;
	localparam logic [2:0]  BT_END          = 3'h4;
	localparam logic [2:0]  BT_PAYLOAD      = 3'h5;
	localparam logic [3:0]  WORD_COUNT      = 4'h3;

	localparam logic [1:0]  LATE_ENTRY_FRAMES = 2'h2;
	localparam logic [1:0]  SF_LAST_FRAME     = 2'h3;
	localparam logic [1:0]  CCH_LAST          = 2'h3;
	localparam logic [3:0]  LLR_PER_BLOCK     = 4'hC;

	typedef enum logic [2:0] {S_IDLE, S_HUNT, S_MSG, S_CCH, S_CALL} frh_state_type;

	typedef struct packed {
		logic [2:0]  kind;
		logic        crc_ok;
		logic        copy;
		logic [3:0]  colour;
		logic        all_call;
		logic        voice;
		logic [23:0] target;
		logic [47:0] data;
	} frh_block_type;
endpackage

// ---- test/frh_frame_handler_monitor.sv ----
`timescale 1ns/100ps
module frh_frame_handler_monitor (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic psel_i,
	input  wire logic penable_i,
	input  wire logic pready_o,
	input  wire logic frame_tick_i,
	input  wire logic burst_start_sync_i,
	input  wire logic mid_call_sync_i,
	input  wire logic blk_valid_i,
	input  wire logic demod_en_o,
	input  wire logic sync_found_irq_o,
	input  wire logic call_accepted_irq_o,
	input  wire logic event_irq_o,
	input  wire logic block_ready_irq_o,
	input  wire logic voc_en_o,
	input  wire logic voc_llr_valid_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ready;
		psel_i && !penable_i |=> pready_o;
	endproperty
	property p_sync_cause;
		sync_found_irq_o |-> $past(burst_start_sync_i) || $past(mid_call_sync_i);
	endproperty
	property p_sync_demod;
		sync_found_irq_o |-> demod_en_o && !$past(demod_en_o);
	endproperty
	property p_acc_cause;
		call_accepted_irq_o |-> $past(blk_valid_i) && block_ready_irq_o;
	endproperty
	property p_acc_pulse;
		call_accepted_irq_o |=> !call_accepted_irq_o;
	endproperty
	property p_blk_cause;
		block_ready_irq_o |-> $past(blk_valid_i);
	endproperty
	property p_event_cause;
		event_irq_o |-> $past(blk_valid_i) || $past(frame_tick_i);
	endproperty
	property p_llr_gate;
		voc_llr_valid_o |-> voc_en_o;
	endproperty
	property p_voc_in_call;
		voc_en_o |-> demod_en_o;
	endproperty
	a_ready: assert property (p_ready) else $error("no access cycle");
	a_sync_cause: assert property (p_sync_cause) else $error("stray sync irq");
	a_sync_demod: assert property (p_sync_demod) else $error("demod not enabled");
	a_acc_cause: assert property (p_acc_cause) else $error("stray accept irq");
	a_acc_pulse: assert property (p_acc_pulse) else $error("accept irq too long");
	a_blk_cause: assert property (p_blk_cause) else $error("stray block irq");
	a_event_cause: assert property (p_event_cause) else $error("stray event irq");
	a_llr_gate: assert property (p_llr_gate) else $error("llr with vocoder off");
	a_voc_in_call: assert property (p_voc_in_call) else $error("vocoder outside call");
	c_sync: cover property (sync_found_irq_o);
	c_acc: cover property (call_accepted_irq_o);
	c_event: cover property (event_irq_o);
	c_llr: cover property (voc_llr_valid_o);
endmodule

// ---- test/frh_frame_handler_tb.sv ----
`timescale 1ns/100ps
module frh_frame_handler_tb;
	import frh_pkg::*;
	logic          clk_i, rst_i, psel, penable, pwrite, pready, pslverr;
	logic [11:0]   paddr;
	logic [31:0]   pwdata, prdata;
	logic          tick, s_ok, bss, mcs, vld, llr_v;
	logic [3:0]    llr;
	logic [15:0]   hw;
	logic [33:0]   e;
	frh_block_type b, lb, lblk;
	logic [33:0]   rq[$];
	logic [3:0]    lq[$];
	int            n_mismatch, samples_checked;

	frh_frame_handler dut_u (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .frame_tick_i(tick),
		.frame_sync_ok_i(s_ok), .burst_start_sync_i(bss), .mid_call_sync_i(mcs),
		.blk_valid_i(vld), .blk_i(lblk), .demod_en_o(), .sync_found_irq_o(),
		.call_accepted_irq_o(), .event_irq_o(), .block_ready_irq_o(), .voc_en_o(),
		.voc_llr_valid_o(llr_v), .voc_llr_o(llr));
	frh_link_model lk (.clk_i(clk_i), .frame_tick_o(tick), .sync_ok_o(s_ok),
		.burst_sync_o(bss), .mid_sync_o(mcs), .blk_valid_o(vld), .blk_o(lblk));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic chk(input string w, input logic [16:0] x, input logic [16:0] s);
		samples_checked++;
		if (s !== x) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", w, x, s);
		end
	endtask

	// Results are compared where they appear, in queue order
	always @(posedge clk_i) begin
		if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0) begin
			e = rq.pop_front();
			chk("read", e[16:0], {pslverr, prdata[15:0]} & e[33:17]);
		end
		if (llr_v === 1'b1)
			chk("llr", lq.size() > 0 ? {13'h0, lq.pop_front()} : 17'h10000, {13'h0, llr});
	end

	task automatic stop_test();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [9:0] i, input logic [15:0] d);
		int k;
		@(posedge clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {16'h0000, d};
		@(posedge clk_i);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			n_mismatch++;
			stop_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [9:0] i, input logic [15:0] d);
		apb(1'b1, i, d);
	endtask
	task automatic rd(input logic [9:0] i, input logic [15:0] x, input logic [16:0] m = 17'h0FFFF);
		rq.push_back({m, {1'b0, x} & m});
		apb(1'b0, i, 16'h0000);
	endtask
	task automatic state(input frh_state_type s);
		rd(IDX_STATUS, {9'h000, s, 4'h0}, 17'h00070);
	endtask
	task automatic st(input logic [15:0] c);
		wr(IDX_MODE_CTRL, MODE_RESET);
		wr(IDX_MODEM_CFG, c);
		wr(IDX_MODE_CTRL, MODE_RX);
	endtask
	task automatic blk(input logic [2:0] k, input logic c);
		b.kind = k;
		b.crc_ok = c;
		b.data = 48'({$urandom, $urandom});
		if (b.voice && k == BT_PAYLOAD)
			for (int j = 11; j >= 0; j--) lq.push_back(b.data[4*j+:4]);
		lk.go(2'h3, 1'b1, b);
	endtask
	task automatic call();
		lk.go(2'h1, 1'b1, b);
		blk(BT_MESSAGE, 1'b1);
	endtask
	task automatic words();
		rd(IDX_RX_WORD0, {b.data[47:40], 1'b0, b.kind, WORD_COUNT});
		rd(IDX_RX_WORD1, b.data[39:24]);
		rd(IDX_RX_WORD2, b.data[23:8]);
		rd(IDX_RX_WORD3, {b.data[7:0], 8'h00});
	endtask

	initial begin
		rst_i = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		b = '0;
		n_mismatch = 0;
		samples_checked = 0;
		void'($urandom(32'h92A3));
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(IDX_MODEM_CFG, CFG_RESET);
		rd(IDX_MODE_CTRL, MODE_RESET);
		rd(IDX_AUX, AUX_RESET);
		rd(IDX_CORRUPT_THR, THR_RESET);
		wr(IDX_RX_WORD0, 16'hFFFF);
		rd(IDX_RX_WORD0, 16'h0000);
		rq.push_back({17'h1FFFF, 17'h10000});
		apb(1'b0, 10'h0FF, 16'h0000);
		$display("test registers done");
		st(16'h0000);
		state(S_HUNT);
		lk.go(2'h1, 1'b1, b);
		state(S_MSG);
		blk(BT_MESSAGE, 1'b1);
		state(S_CALL);
		words();
		blk(BT_CCH, 1'b1);
		words();
		blk(BT_END, 1'b1);
		words();
		state(S_HUNT);
		$display("test burst call done");
		st(16'h0400);
		wr(IDX_AUX, 16'h0005);
		b.colour = 4'h6;
		call();
		state(S_HUNT);
		b.colour = 4'h5;
		call();
		state(S_CALL);
		st(16'h0200);
		wr(IDX_OWN_ID_LO, 16'h3456);
		wr(IDX_OWN_ID_HI, 16'h0012);
		b.target = 24'h123457;
		call();
		state(S_HUNT);
		b.target = 24'h123456;
		call();
		state(S_CALL);
		st(16'h0200);
		b.all_call = 1'b1;
		b.target = 24'h000001;
		call();
		state(S_CALL);
		b.all_call = 1'b0;
		st(16'h1200);
		call();
		state(S_CALL);
		$display("test call filter done");
		st(16'h0000);
		lk.go(2'h1, 1'b1, b);
		blk(BT_MESSAGE, 1'b0);
		b.copy = 1'b1;
		blk(BT_MESSAGE, 1'b1);
		b.copy = 1'b0;
		state(S_CALL);
		words();
		lb = b;
		blk(BT_MESSAGE, 1'b1);
		b = lb;
		words();
		$display("test duplicates done");
		st(16'h0000);
		lk.go(2'h2, 1'b1, b);
		lk.go(2'h0, 1'b1, b);
		lk.go(2'h2, 1'b1, b);
		state(S_HUNT);
		lk.go(2'h0, 1'b1, b);
		lk.go(2'h0, 1'b1, b);
		lk.go(2'h2, 1'b1, b);
		state(S_CCH);
		blk(BT_CCH, 1'b1);
		state(S_CALL);
		blk(BT_CCH, 1'b1);
		words();
		rd(IDX_STATUS, 16'h0001, 17'h00003);
		wr(IDX_STATUS, 16'h0001);
		rd(IDX_STATUS, 16'h0000, 17'h00001);
		st(16'h0200);
		lk.go(2'h2, 1'b1, b);
		repeat (2) lk.go(2'h0, 1'b1, b);
		lk.go(2'h2, 1'b1, b);
		b.kind = BT_CCH;
		b.crc_ok = 1'b1;
		b.data[11:0] = 12'h123;
		lk.go(2'h3, 1'b1, b);
		state(S_CCH);
		b.data[11:0] = 12'h456;
		lk.go(2'h3, 1'b1, b);
		b.data[11:0] = 12'h000;
		repeat (2) lk.go(2'h3, 1'b1, b);
		state(S_CALL);
		rd(IDX_RX_WORD0, {8'h12, 1'b0, BT_MESSAGE, WORD_COUNT});
		rd(IDX_RX_WORD1, 16'h3456);
		$display("test late entry done");
		st(16'h0001);
		b.voice = 1'b1;
		call();
		rd(IDX_STATUS, 16'h0008, 17'h00008);
		blk(BT_PAYLOAD, 1'b1);
		repeat (20) @(posedge clk_i);
		blk(BT_END, 1'b1);
		rd(IDX_STATUS, 16'h0010, 17'h00078);
		b.voice = 1'b0;
		$display("test vocoder done");
		st(16'h0002);
		call();
		blk(BT_PAYLOAD, 1'b1);
		hw = 16'h0000;
		for (int j = 0; j < 12; j++) hw[j] = b.data[4*j+3];
		rd(IDX_RX_WORD1, hw);
		$display("test hard payload done");
		wr(IDX_CORRUPT_THR, 16'h0001);
		st(16'h0000);
		call();
		repeat (8) lk.go(2'h0, 1'b0, b);
		state(S_HUNT);
		$display("test corrupt superframes done");
		repeat (3) @(posedge clk_i);
		chk("llr left", 17'h00000, 17'(lq.size()));
		stop_test();
	end

	// About fifty times the expected run length
	initial begin
		#200000;
		n_mismatch++;
		stop_test();
	end
endmodule

bind frh_frame_handler frh_frame_handler_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i),
	.psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o),
	.frame_tick_i(frame_tick_i), .burst_start_sync_i(burst_start_sync_i),
	.mid_call_sync_i(mid_call_sync_i), .blk_valid_i(blk_valid_i),
	.demod_en_o(demod_en_o), .sync_found_irq_o(sync_found_irq_o),
	.call_accepted_irq_o(call_accepted_irq_o), .event_irq_o(event_irq_o),
	.block_ready_irq_o(block_ready_irq_o), .voc_en_o(voc_en_o),
	.voc_llr_valid_o(voc_llr_valid_o));

// ---- test/frh_link_model.sv ----
`timescale 1ns/100ps
module frh_link_model
	import frh_pkg::*;
(
	input  wire logic     clk_i,
	output logic          frame_tick_o,
	output logic          sync_ok_o,
	output logic          burst_sync_o,
	output logic          mid_sync_o,
	output logic          blk_valid_o,
	output frh_block_type blk_o
);
	initial begin
		{frame_tick_o, sync_ok_o, burst_sync_o, mid_sync_o, blk_valid_o} = 5'h00;
		blk_o = '0;
	end
	// Released block lines show the inverse so stale data never matches the last block driven
	task automatic go(input logic [1:0] k, input logic ok, input frh_block_type b);
		@(posedge clk_i);
		frame_tick_o <= (k == 2'h0);
		sync_ok_o <= ok;
		burst_sync_o <= (k == 2'h1);
		mid_sync_o <= (k == 2'h2);
		blk_valid_o <= (k == 2'h3);
		blk_o <= b;
		@(posedge clk_i);
		{frame_tick_o, burst_sync_o, mid_sync_o, blk_valid_o} <= 4'h0;
		blk_o <= ~b;
	endtask
endmodule
